// [hs_channel.sv]
`timescale 1ns/1ps
module hs_channel
  import pio_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // handshake carrier
  hs_if.chan       hs
);
  typedef struct packed {
    logic input_full;
    logic full_int;
    logic output_full_n;
    logic rdy;
    logic stb_d;
    logic ack_d;
  } chan_s;
  chan_s s_q;
  chan_s s_d;

  // flag updates; each set follows its pin or port clear so it wins, but a disabled direction clears last
  always_comb begin
    s_d = s_q;
    s_d.stb_d = hs.stb_n;
    s_d.ack_d = hs.ack_n;
    if (hs.rd) begin
      s_d.input_full = 1'h0;
      s_d.full_int = 1'h0;
    end
    if (!hs.stb_n) s_d.input_full = 1'h1;
    if (hs.stb_n && !s_q.stb_d && s_q.input_full) s_d.full_int = 1'h1;
    if (!hs.in_en) begin
      s_d.input_full = 1'h0;
      s_d.full_int = 1'h0;
    end
    if (!hs.ack_n) s_d.output_full_n = 1'h0;
    if (hs.wr || hs.early) s_d.rdy = 1'h0;
    if (hs.wr) s_d.output_full_n = 1'h1;
    if (hs.ack_n && !s_q.ack_d) s_d.rdy = 1'h1;
    if (!hs.out_en) begin
      s_d.output_full_n = 1'h0;
      s_d.rdy = 1'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
    end else begin
      s_q <= s_d;
    end
  end

  // pin and request views; any port access lifts output-full
  assign hs.input_full   = s_q.input_full;
  assign hs.obf_n = !s_q.output_full_n || hs.acc;
  assign hs.service_request  = (s_q.full_int && hs.ie_in)
                 || (s_q.rdy && hs.ie_out);
  assign hs.load  = hs.in_en && !hs.stb_n;

  sequence s_stb_pulse;
    (!hs.stb_n && hs.in_en) ##1 (hs.stb_n && hs.in_en && !hs.rd);
  endsequence
  sequence s_ack_pulse;
    (!hs.ack_n && hs.out_en) ##1
      (hs.ack_n && hs.out_en && !hs.wr && !hs.early);
  endsequence

  a_strobe_sets_full: assert property (@(posedge pclk)
    disable iff (!presetn) hs.in_en && !hs.stb_n |=> hs.input_full)
    else $error("input-full not set by strobe");
  a_read_clears_full: assert property (@(posedge pclk)
    disable iff (!presetn) hs.rd && hs.stb_n |=> !hs.input_full)
    else $error("input-full not cleared by read");
  a_input_service: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_stb_pulse ##0 hs.ie_in |=> hs.service_request || !hs.ie_in)
    else $error("input service request missing");
  a_write_sets_full: assert property (@(posedge pclk)
    disable iff (!presetn) hs.out_en && hs.wr |=> s_q.output_full_n)
    else $error("output-full not set by write");
  a_ready_service: assert property (@(posedge pclk)
    disable iff (!presetn) s_ack_pulse |=> s_q.rdy)
    else $error("ready flag not set after accept");
  a_access_lifts: assert property (@(posedge pclk)
    disable iff (!presetn) hs.acc |-> hs.obf_n)
    else $error("output-full low during access");
endmodule

// [hs_if.sv]
`timescale 1ns/1ps
interface hs_if;
  logic stb_n;
  logic ack_n;
  logic in_en;
  logic out_en;
  logic ie_in;
  logic ie_out;
  logic rd;
  logic wr;
  logic early;
  logic acc;
  logic input_full;
  logic obf_n;
  logic service_request;
  logic load;
  modport ctl (output stb_n, ack_n, in_en, out_en, ie_in, ie_out,
               rd, wr, early, acc, input input_full, obf_n, service_request, load);
  modport chan (input stb_n, ack_n, in_en, out_en, ie_in, ie_out,
                rd, wr, early, acc, output input_full, obf_n, service_request, load);
endinterface

// [parallel_io_handshake_port.sv]
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module parallel_io_handshake_port
  import pio_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // port a pins
  input  wire logic [7:0]  pa_i,
  output logic [7:0]       pa_o,
  output logic [7:0]       pa_oe,
  // port b pins
  input  wire logic [7:0]  pb_i,
  output logic [7:0]       pb_o,
  output logic [7:0]       pb_oe,
  // port c pins
  input  wire logic [7:0]  pc_i,
  output logic [7:0]       pc_o,
  output logic [7:0]       pc_oe,
  // service requests
  output logic             port_a_service_request,
  output logic             port_b_service_request,
  output logic [7:0]       irq_vector
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cw;
    logic [7:0]  pa_out;
    logic [7:0]  pb_out;
    logic [7:0]  pc;
    logic [7:0]  pa_in;
    logic [7:0]  pb_in;
    logic [7:0]  pa_s1;
    logic [7:0]  pa_s2;
    logic [7:0]  pb_s1;
    logic [7:0]  pb_s2;
    logic [7:0]  pc_s1;
    logic [7:0]  pc_s2;
    logic [31:0] rdata;
    logic        err;
    logic [7:0]  vec;
  } top_s;
  top_s s_q;
  top_s s_d;

  hs_if ch_a ();
  hs_if ch_b ();

  logic       dir_out;
  a_mode_e    am;
  logic       a_in;
  logic       b_m1;
  logic       b_in;
  logic       setup;
  logic       access;
  logic       mapped;
  logic [7:0] pc_drv;
  logic [7:0] pc_en;
  logic [7:0] pc_rd;
  logic [7:0] pa_rd;
  logic [7:0] pb_rd;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // port a mode from a control word; mode 2 outranks mode 1
  function automatic a_mode_e a_mode(input logic [15:0] w);
    a_mode_e m;
    m = A_MODE0;
    if (w[CW_A_MODE2]) begin
      m = A_MODE2;
    end else if (w[CW_A_MODE1]) begin
      m = A_MODE1;
    end
    return m;
  endfunction

  // true when this apb address selects the given register
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign am     = a_mode(s_q.cw);
  assign a_in   = s_q.cw[CW_A_IN];
  assign b_m1   = s_q.cw[CW_B_MODE1];
  assign b_in   = s_q.cw[CW_B_IN];
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign mapped = hit(paddr, OFS_PORT_A) || hit(paddr, OFS_PORT_B)
               || hit(paddr, OFS_PORT_C) || hit(paddr, OFS_CTRL);

  // ----------------------------------------------------------------
  // handshake channels
  // ----------------------------------------------------------------
  // port a: strobe on line 4, accept on line 6, mode 2 uses both
  assign ch_a.in_en  = (am == A_MODE2) || (am == A_MODE1 && a_in);
  assign ch_a.out_en = (am == A_MODE2) || (am == A_MODE1 && !a_in);
  assign ch_a.stb_n  = s_q.pc_s2[PC_A_STB];
  assign ch_a.ack_n  = s_q.pc_s2[PC_A_ACK];
  assign ch_a.ie_in  = s_q.pc[PC_A_STB];
  assign ch_a.ie_out = s_q.pc[PC_A_ACK];
  assign ch_a.rd     = access && !pwrite && hit(paddr, OFS_PORT_A);
  assign ch_a.wr     = access && pwrite && hit(paddr, OFS_PORT_A);
  assign ch_a.early  = 1'h0;
  assign ch_a.acc    = psel && hit(paddr, OFS_PORT_A);

  // port b: one line serves as strobe or accept by direction
  assign ch_b.in_en  = b_m1 && b_in;
  assign ch_b.out_en = b_m1 && !b_in;
  assign ch_b.stb_n  = s_q.pc_s2[PC_B_STB];
  assign ch_b.ack_n  = s_q.pc_s2[PC_B_STB];
  // no port b interrupts while port a is bidirectional
  assign ch_b.ie_in  = s_q.pc[PC_B_STB] && am != A_MODE2;
  assign ch_b.ie_out = s_q.pc[PC_B_STB] && am != A_MODE2;
  assign ch_b.rd     = access && !pwrite && hit(paddr, OFS_PORT_B);
  assign ch_b.wr     = access && pwrite && hit(paddr, OFS_PORT_B);
  // the setup cycle of a write stands for the implied read
  assign ch_b.early  = setup && pwrite && hit(paddr, OFS_PORT_B);
  assign ch_b.acc    = psel && hit(paddr, OFS_PORT_B);

  hs_channel u_chan_a (
    .pclk    (pclk),
    .presetn (presetn),
    .hs      (ch_a)
  );

  hs_channel u_chan_b (
    .pclk    (pclk),
    .presetn (presetn),
    .hs      (ch_b)
  );

  // accept rise is slowed before it turns the port a buffer outward
  rise_delay u_ack_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (s_q.pc_s2[PC_A_ACK]),
    .dout    (dir_out)
  );

  // ----------------------------------------------------------------
  // port c drive and read view
  // ----------------------------------------------------------------
  always_comb begin
    pc_drv = s_q.pc;
    // lines 7, 5, 3, 1 and 0 have outward-only buffers
    pc_en  = {1'h1, !s_q.cw[CW_CU_IN], 1'h1, !s_q.cw[CW_CU_IN],
              1'h1, !s_q.cw[CW_CL_IN], 2'h3};
    if (am != A_MODE0) begin
      // upper handshake lines leave general use
      pc_drv[PC_A_SERVICE_REQUEST] = ch_a.service_request;
      pc_en[PC_A_SERVICE_REQUEST]  = 1'h1;
      if (ch_a.in_en) begin
        pc_drv[PC_A_IBF] = ch_a.input_full;
        pc_en[PC_A_IBF]  = 1'h1;
        pc_en[PC_A_STB]  = 1'h0;
      end
      if (ch_a.out_en) begin
        pc_drv[PC_A_OBF] = ch_a.obf_n;
        pc_en[PC_A_OBF]  = 1'h1;
        pc_en[PC_A_ACK]  = 1'h0;
      end
    end
    if (b_m1) begin
      pc_drv[PC_B_SERVICE_REQUEST] = ch_b.service_request;
      pc_en[PC_B_SERVICE_REQUEST]  = 1'h1;
      pc_drv[PC_B_FULL] = b_in ? ch_b.input_full : ch_b.obf_n;
      pc_en[PC_B_FULL]  = 1'h1;
      pc_en[PC_B_STB]   = 1'h0;
    end
  end

  // driven lines read back, input lines read the pin, and the
  // strobe/accept positions show the enables kept behind them
  always_comb begin
    pc_rd = (pc_en & pc_drv) | (~pc_en & s_q.pc_s2);
    if (ch_a.in_en) pc_rd[PC_A_STB] = s_q.pc[PC_A_STB];
    if (ch_a.out_en) pc_rd[PC_A_ACK] = s_q.pc[PC_A_ACK];
    if (b_m1) pc_rd[PC_B_STB] = s_q.pc[PC_B_STB];
  end

  // ----------------------------------------------------------------
  // port a and b read views
  // ----------------------------------------------------------------
  always_comb begin
    if (ch_a.in_en) begin
      pa_rd = s_q.pa_in;
    end else if (a_in) begin
      pa_rd = s_q.pa_s2;
    end else begin
      pa_rd = s_q.pa_out;
    end
    if (ch_b.in_en) begin
      pb_rd = s_q.pb_in;
    end else if (b_in) begin
      pb_rd = s_q.pb_s2;
    end else begin
      pb_rd = s_q.pb_out;
    end
  end

  // read mux; the control word never reads back
  always_comb begin
    rd_byte = 8'h00;
    if (hit(paddr, OFS_PORT_A)) rd_byte = pa_rd;
    if (hit(paddr, OFS_PORT_B)) rd_byte = pb_rd;
    if (hit(paddr, OFS_PORT_C)) rd_byte = pc_rd;
    if (hit(paddr, OFS_CTRL)) rd_byte = 8'h00;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // two stages on every pin before any logic looks
    s_d.pa_s1 = pa_i;
    s_d.pa_s2 = s_q.pa_s1;
    s_d.pb_s1 = pb_i;
    s_d.pb_s2 = s_q.pb_s1;
    s_d.pc_s1 = pc_i;
    s_d.pc_s2 = s_q.pc_s1;
    // input latches follow the pins while the strobe is low
    if (ch_a.load) s_d.pa_in = s_q.pa_s2;
    if (ch_b.load) s_d.pb_in = s_q.pb_s2;
    // read data is caught in setup so prdata comes from a flop
    if (setup) begin
      s_d.rdata = {24'h00_0000, rd_byte};
      s_d.err   = !mapped;
    end
    // writes take effect in the access phase
    if (access && pwrite) begin
      if (hit(paddr, OFS_PORT_A)) s_d.pa_out = pwdata[7:0];
      if (hit(paddr, OFS_PORT_B)) s_d.pb_out = pwdata[7:0];
      if (hit(paddr, OFS_CTRL)) begin
        if (pwdata[CW_DEFINE]) begin
          s_d.cw = pwdata[15:0];
        end else begin
          s_d.pc[pwdata[CW_IDX_HI:CW_IDX_LO]] = pwdata[CW_VALUE];
        end
      end
    end
    // port a outranks port b when both request
    if (ch_a.service_request) begin
      s_d.vec = VEC_PORT_A;
    end else if (ch_b.service_request) begin
      s_d.vec = VEC_PORT_B;
    end else begin
      s_d.vec = 8'h00;
    end
  end

  // port c reset high also leaves any port-c-steered buffer as output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.cw     <= CW_RESET;
      s_q.pa_out <= PORT_RESET;
      s_q.pb_out <= PORT_RESET;
      s_q.pc     <= PC_RESET;
      s_q.pc_s1  <= PC_RESET;
      s_q.pc_s2  <= PC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata  = s_q.rdata;
  assign pready  = 1'h1;
  assign pslverr = s_q.err && access;
  assign pa_o    = s_q.pa_out;
  assign pb_o    = s_q.pb_out;
  assign pc_o    = pc_drv;
  assign pc_oe   = pc_en;
  // bidirectional port a turns by the delayed accept level
  assign pa_oe   = (am == A_MODE2) ? {8{dir_out}}
                 : {8{!a_in}};
  assign pb_oe   = {8{!b_in}};
  assign port_a_service_request = ch_a.service_request;
  assign port_b_service_request = ch_b.service_request;
  assign irq_vector = s_q.vec;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ctrl_read_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    access && !pwrite && hit(paddr, OFS_CTRL) |-> prdata == 32'h0000_0000)
    else $error("control register read back its content");
  a_bit_set_reset: assert property (@(posedge pclk)
    disable iff (!presetn)
    access && pwrite && hit(paddr, OFS_CTRL) && !pwdata[CW_DEFINE]
    |=> s_q.pc[$past(pwdata[3:1])] == $past(pwdata[0]))
    else $error("port c bit not set or cleared");
  a_mode_define: assert property (@(posedge pclk)
    disable iff (!presetn)
    access && pwrite && hit(paddr, OFS_CTRL) && pwdata[CW_DEFINE]
    |=> s_q.cw[7:0] == $past(pwdata[7:0]))
    else $error("mode word not taken");
  a_b_quiet_mode2: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_q.cw[CW_A_MODE2] |-> !port_b_service_request)
    else $error("port b request while port a is bidirectional");
endmodule

// [parallel_io_handshake_port_tb.sv]
`timescale 1ns/1ps
module parallel_io_handshake_port_tb;
  import pio_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, pc_i, pc_o, pc_oe;
  logic        port_a_service_request;
  logic        port_b_service_request;
  logic [7:0]  irq_vector;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  acc_pc;  // port c as seen during the access phase
  int          failures     = 0;
  int          total_checks = 0;

  always #5 pclk = ~pclk;

  parallel_io_handshake_port i_parallel_io_handshake_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pa_i(pa_i), .pa_o(pa_o),
    .pa_oe(pa_oe), .pb_i(pb_i), .pb_o(pb_o), .pb_oe(pb_oe),
    .pc_i(pc_i), .pc_o(pc_o), .pc_oe(pc_oe),
    .port_a_service_request(port_a_service_request),
    .port_b_service_request(port_b_service_request),
    .irq_vector(irq_vector));

  pio_partner i_pio_partner (
    .pclk(pclk), .pa_o(pa_o), .pa_oe(pa_oe), .pb_o(pb_o), .pb_oe(pb_oe),
    .pc_o(pc_o), .pc_oe(pc_oe), .pa_i(pa_i), .pb_i(pb_i), .pc_i(pc_i));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // apb master: hold the request until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    acc_pc = pc_o;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      end_of_test();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // watched outputs, selected by number
  function automatic logic sig(input int s);
    case (s)
      0: return port_a_service_request;
      1: return port_b_service_request;
      2: return pc_o[PC_A_IBF];
      3: return pc_o[PC_A_OBF];
      4: return pc_o[PC_B_FULL];
      default: return pa_oe[0];
    endcase
  endfunction

  // bounded wait; a miss ends the run
  task automatic wait_until(input int s, input logic v, input int lim,
                            input string what);
    int n;
    n = 0;
    @(negedge pclk);
    while (sig(s) !== v && n < lim) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, sig(s)}, {31'h0, v}, what);
    if (sig(s) !== v) begin
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(pc_o, 8'hFF, "pc value");
    chk(pc_oe, 8'hFF, "pc drive");
    chk({pa_o, pa_oe}, 16'hFFFF, "pa reset");
    chk({port_a_service_request, port_b_service_request}, 0, "req");
    rreg(OFS_CTRL);
    chk(rd, 0, "ctrl read");
    chk(err, 0, "ctrl no error");
    rreg(8'h10);
    chk(err, 1, "unmapped");
    $display("test reset finished");
    for (int i = 0; i < 8; i++) begin
      wreg(OFS_CTRL, {1'b0, 3'b111, 3'(i), 1'b0});
      @(negedge pclk);
      chk(pc_o, 8'hFF & ~(8'h01 << i), "bit clear");
      wreg(OFS_CTRL, {4'b0000, 3'(i), 1'b1});
      @(negedge pclk);
      chk(pc_o, 8'hFF, "bit set");
    end
    wreg(OFS_PORT_A, 8'h5A);
    @(negedge pclk);
    chk(pa_o, 8'h5A, "mode 0 out");
    wreg(OFS_CTRL, 8'h9B);
    i_pio_partner.set_data(8'h3C, 8'hC3);
    @(negedge pclk);
    chk({pa_oe, pb_oe}, 0, "inputs");
    chk(pc_oe, 8'hAB, "pc inputs");
    rreg(OFS_PORT_A);
    chk(rd, 8'h3C, "mode 0 in a");
    rreg(OFS_PORT_B);
    chk(rd, 8'hC3, "mode 0 in b");
    $display("test mode 0 finished");
    // port a strobed input
    wreg(OFS_CTRL, 8'hB8);
    wreg(OFS_CTRL, 8'h09);
    i_pio_partner.pulse(PC_A_STB, 6, 8'hA5);
    @(negedge pclk);
    chk(pc_o[PC_A_IBF], 1, "input full");
    wait_until(0, 1'b1, 8, "in request");
    @(negedge pclk);
    chk(irq_vector, VEC_PORT_A, "vector a");
    rreg(OFS_PORT_A);
    chk(rd, 8'hA5, "latched");
    wait_until(2, 1'b0, 4, "full clear");
    chk(port_a_service_request, 0, "req clear");
    wreg(OFS_CTRL, 8'h08);
    i_pio_partner.pulse(PC_A_STB, 6, 8'h11);
    repeat (10) @(negedge pclk);
    chk(port_a_service_request, 0, "masked");
    chk(pc_o[PC_A_IBF], 1, "full held");
    rreg(OFS_PORT_A);
    chk(rd, 8'h11, "second byte");
    $display("test strobed input finished");
    // port a strobed output
    wreg(OFS_CTRL, 8'hA8);
    wreg(OFS_CTRL, 8'h0D);
    wreg(OFS_PORT_A, 8'h33);
    wait_until(3, 1'b0, 4, "out full a");
    rreg(OFS_PORT_A);
    chk(acc_pc[PC_A_OBF], 1, "lifted");
    wait_until(3, 1'b0, 4, "relowered");
    i_pio_partner.pulse(PC_A_ACK, 3, 8'h00);
    wait_until(0, 1'b1, 10, "out request");
    chk(pc_o[PC_A_OBF], 1, "taken");
    wreg(OFS_PORT_A, 8'h44);
    wait_until(0, 1'b0, 3, "a drop");
    $display("test strobed output a finished");
    // port b strobed output
    wreg(OFS_CTRL, 8'h84);
    wreg(OFS_CTRL, 8'h05);
    wreg(OFS_PORT_B, 8'h77);
    wait_until(4, 1'b0, 4, "out full b");
    i_pio_partner.pulse(PC_B_STB, 3, 8'h00);
    wait_until(1, 1'b1, 10, "b request");
    @(negedge pclk);
    chk(irq_vector, VEC_PORT_B, "vector b");
    wreg(OFS_PORT_B, 8'h78);
    wait_until(1, 1'b0, 3, "b drop");
    chk(pb_o, 8'h78, "b latch");
    // port b strobed input, enable kept in line 2
    wreg(OFS_CTRL, 8'h86);
    i_pio_partner.pulse(PC_B_STB, 6, 8'hB4);
    @(negedge pclk);
    chk(pc_o[PC_B_FULL], 1, "b input full");
    wait_until(1, 1'b1, 10, "b in request");
    rreg(OFS_PORT_B);
    chk(rd, 8'hB4, "b latched");
    $display("test strobed output b finished");
    // port a bidirectional
    wreg(OFS_CTRL, 8'hCC);
    @(negedge pclk);
    chk(pc_oe[7:3], 5'b10101, "pc handshake");
    wreg(OFS_CTRL, 8'h05);
    fork
      i_pio_partner.pulse(PC_A_ACK, 8, 8'h00);
      wait_until(5, 1'b0, 6, "turn in");
    join
    repeat (18) @(negedge pclk);
    chk(pa_oe[0], 0, "still in");
    wait_until(5, 1'b1, 15, "turn out");
    // mode 2 input byte is read out before port a is written
    i_pio_partner.pulse(PC_A_STB, 6, 8'h96);
    @(negedge pclk);
    chk(pc_o[PC_A_IBF], 1, "mode 2 full");
    rreg(OFS_PORT_A);
    wait_until(2, 1'b0, 4, "mode 2 saved");
    wreg(OFS_PORT_A, 8'h69);
    wait_until(3, 1'b0, 4, "mode 2 out full");
    wreg(OFS_PORT_B, 8'h55);
    i_pio_partner.pulse(PC_B_STB, 3, 8'h00);
    repeat (8) @(negedge pclk);
    chk(port_b_service_request, 0, "b quiet");
    $display("test bidirectional finished");
    end_of_test();
  end
endmodule

// [pio_partner.sv]
`timescale 1ns/1ps
module pio_partner (
  // clock
  input  wire logic       pclk,
  // device side of the pins
  input  wire logic [7:0] pa_o,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pb_o,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pc_o,
  input  wire logic [7:0] pc_oe,
  // resolved pin levels
  output logic [7:0]      pa_i,
  output logic [7:0]      pb_i,
  output logic [7:0]      pc_i
);
  logic [7:0] pa_drv = 8'h00;
  logic [7:0] pb_drv = 8'h00;
  logic [7:0] pc_drv = 8'hFF;  // strobe and accept idle high

  // a line shows the device where it drives, else the far side
  assign pa_i = (pa_oe & pa_o) | (~pa_oe & pa_drv);
  assign pb_i = (pb_oe & pb_o) | (~pb_oe & pb_drv);
  assign pc_i = (pc_oe & pc_o) | (~pc_oe & pc_drv);

  // static data for unlatched reads
  task automatic set_data(input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    pa_drv <= a;
    pb_drv <= b;
    // let the two synchroniser stages settle before any read
    repeat (3) @(posedge pclk);
  endtask

  // low pulse on one port c line; data held until one cycle after it rises
  task automatic pulse(input int line, input int n, input logic [7:0] d);
    @(posedge pclk);
    pa_drv <= d;
    pb_drv <= d;
    pc_drv[line] <= 1'b0;
    repeat (n) @(posedge pclk);
    pc_drv[line] <= 1'b1;
    @(posedge pclk);
    // hold time over: inverted data catches a late sample
    pa_drv <= ~d;
    pb_drv <= ~d;
  endtask
endmodule

// [pio_pkg.sv]
package pio_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PORT_A = 8'h00;
  localparam logic [7:0] OFS_PORT_B = 8'h04;
  localparam logic [7:0] OFS_PORT_C = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;
  // control word fields
  localparam int CW_DEFINE  = 7;
  localparam int CW_A_MODE2 = 6;
  localparam int CW_A_MODE1 = 5;
  localparam int CW_A_IN    = 4;
  localparam int CW_CU_IN   = 3;
  localparam int CW_B_MODE1 = 2;
  localparam int CW_B_IN    = 1;
  localparam int CW_CL_IN   = 0;
  localparam int CW_IDX_HI  = 3;
  localparam int CW_IDX_LO  = 1;
  localparam int CW_VALUE   = 0;
  // port c line use under handshake
  localparam int PC_B_SERVICE_REQUEST = 0;
  localparam int PC_B_FULL = 1;
  localparam int PC_B_STB  = 2;
  localparam int PC_A_SERVICE_REQUEST = 3;
  localparam int PC_A_STB  = 4;
  localparam int PC_A_IBF  = 5;
  localparam int PC_A_ACK  = 6;
  localparam int PC_A_OBF  = 7;
  // reset values and vectors (octal 134 and 130)
  localparam logic [15:0] CW_RESET   = 16'h0080;
  localparam logic [7:0]  PORT_RESET = 8'hFF;
  localparam logic [7:0]  PC_RESET   = 8'hFF;
  localparam logic [7:0]  VEC_PORT_A = 8'h5C;
  localparam logic [7:0]  VEC_PORT_B = 8'h58;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACK_DELAY_NS  = 250;
  localparam int ACK_DELAY_CYC =
    (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] ACK_DELAY_CNT = 5'(ACK_DELAY_CYC);
  typedef enum logic [1:0] {A_MODE0, A_MODE1, A_MODE2} a_mode_e;
endpackage

// [rise_delay.sv]
`timescale 1ns/1ps
module rise_delay
  import pio_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level in, rise-delayed level out
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       q;
  } dly_s;
  dly_s s_q;
  dly_s s_d;

  // falls pass at once, rises wait the full count
  always_comb begin
    s_d = s_q;
    if (!din) begin
      s_d = '0;
    end else if (s_q.cnt == ACK_DELAY_CNT) begin
      s_d.q = 1'h1;
    end else begin
      s_d.cnt = s_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.q;

  a_dir_fall_fast: assert property (@(posedge pclk)
    disable iff (!presetn) !din |=> !dout)
    else $error("direction did not drop with accept");
  a_dir_rise_late: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(dout) |-> $past(din, 25))
    else $error("direction switched outward too early");
endmodule
